// *** src/codec_route_pkg.sv ***
// Constants shared by the codec routing and gain register bank.
// Assumes a 32-bit AHB-Lite slave port; the routing word holds one register, the group-five word four.
package codec_route_pkg;
	// Bus geometry
	localparam int DATA_W = 32; // Bus data width
	localparam int BYTE_W = 8; // Register width, low byte of the word
	localparam logic [31:0] GROUP_FIVE_OFFSET = 32'h0000_0000; // Sub-addressed gain group
	localparam logic [31:0] ROUTING_OFFSET = 32'h0000_0004; // Output and input routing
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // Transfer kinds that carry a request
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2; // Only whole-word transfers take effect
	// Sub-register select in the top two bits of a group-five byte
	localparam int SUBSEL_HI = 7;
	localparam int SUBSEL_LO = 6;
	localparam logic [1:0] SUB_ADC_GAIN = 2'h0;
	localparam logic [1:0] SUB_DAC_GAIN = 2'h1;
	localparam logic [1:0] SUB_SIDETONE = 2'h2;
	localparam logic [1:0] SUB_VERSION = 2'h3;
	// Field positions
	localparam int PGA_HI = 5;
	localparam int PGA_LO = 0;
	localparam int STG_HI = 5;
	localparam int STG_LO = 3;
	localparam int INPUT_BUFFER_GAIN_SEL_HI = 1;
	localparam int INPUT_BUFFER_GAIN_SEL_LO = 0;
	localparam int VER_W = 4; // Version field D3-D0, D5-D4 reserved
	localparam int ENDED_BIT = 7;
	localparam int MUTE_TWO_BIT = 6;
	localparam int MUTE_THREE_BIT = 5;
	localparam int DRV_HI = 4;
	localparam int DRV_LO = 3;
	localparam int AIN_HI = 2;
	localparam int AIN_LO = 1;
	// Values after reset
	localparam logic [5:0] PGA_RESET = 6'h2a;
	localparam logic [2:0] STG_RESET = 3'h7;
	localparam logic [1:0] INPUT_BUFFER_GAIN_SEL_RESET = 2'h0;
	localparam logic ENDED_RESET = 1'h0;
	localparam logic MUTE_RESET = 1'h0;
	localparam logic [1:0] DRV_RESET = 2'h0;
	localparam logic [1:0] AIN_RESET = 2'h0;
	// Decode constants
	localparam logic [2:0] STG_MUTE_CODE = 3'h7;
	localparam logic [4:0] STG_STEP_DB = 5'h03;
	localparam logic [4:0] INPUT_BUFFER_GAIN_SEL_DB_0 = 5'h00;
	localparam logic [4:0] INPUT_BUFFER_GAIN_SEL_DB_1 = 5'h06;
	localparam logic [4:0] INPUT_BUFFER_GAIN_SEL_DB_2 = 5'h0c;
	localparam logic [4:0] INPUT_BUFFER_GAIN_SEL_DB_3 = 5'h18;
	// Read sequence through group five
	typedef enum logic [3:0] {
		READ_ADC = 4'h1,
		READ_DAC = 4'h2,
		READ_SIDE = 4'h4,
		READ_VER = 4'h8
	} read_slot_type;
endpackage

// *** src/ahb_word_slave.sv ***
// AHB-Lite slave front end: address phase capture and data phase strobes.
// Assumes a single master, word transfers, and a register file with zero wait states.
`timescale 1ns/1ps
module ahb_word_slave (
	clock,
	rstN,
	clockEn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hready,
	hreadyout,
	hresp,
	rdReq,
	reqAddr,
	wrStrobe,
	wrAddr
);
	import codec_route_pkg::*;
	input wire logic clock;
	input wire logic rstN;
	input wire logic clockEn;
	input wire logic hsel;
	input wire logic [31:0] haddr;
	input wire logic [1:0] htrans;
	input wire logic hwrite;
	input wire logic [2:0] hsize;
	input wire logic hready;
	output logic hreadyout;
	output logic hresp;
	output logic rdReq;
	output logic [31:0] reqAddr;
	output logic wrStrobe;
	output logic [31:0] wrAddr;

	logic wrPending_reg; // A write is in its data phase
	logic [31:0] wrAddr_reg; // Address of that write

	// A request is valid NONSEQ/SEQ of word size while the bus is ready
	wire isActive = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire isWord = (hsize == HSIZE_WORD);
	wire takeReq = isActive && isWord && clockEn;

	// Stall while frozen so no data phase completes unseen
	assign hreadyout = clockEn;
	assign hresp = 1'b0;
	assign rdReq = takeReq && !hwrite;
	assign reqAddr = haddr;
	assign wrStrobe = wrPending_reg && clockEn;
	assign wrAddr = wrAddr_reg;

	// Capture write address; data follows in the next cycle
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			wrPending_reg <= 1'b0;
			wrAddr_reg <= 32'h0000_0000;
		end else if (clockEn) begin
			wrPending_reg <= takeReq && hwrite;
			if (takeReq && hwrite) begin
				wrAddr_reg <= haddr;
			end
		end
	end
endmodule // ahb_word_slave

// *** src/codec_route_gain_regs.sv ***
// Routing and gain register bank of a mono voice codec, reached over AHB-Lite.
// Assumes one clock, an active-low asynchronous reset and the analog side wired to the outputs.
`timescale 1ns/1ps
// Contract
// - Sidetone code D5-D3: 111 mute, else attenuation
// - Input buffer code D1-D0: 0/6/12/24 dB
// - D7 selects differential or single-ended outputs
// - D6 mutes analog output two
// - D5 mutes analog output three
// - D4 drives output three, D3 output two
// - D2-D1 select ADC input source
// - Reads cycle ADC, DAC, sidetone, version
module codec_route_gain_regs #(
	parameter logic [3:0] VERSION_ID = 4'h5 // Arbitrary value
) (
	clock,
	nrst,
	clockEn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hrdata,
	hreadyout,
	hresp,
	adcGain,
	dacGain,
	sidetoneGainSel,
	sidetoneMute,
	sidetoneAttenDb,
	inputBufferGainSel,
	inputBufferGainDb,
	outputEndedSel,
	outTwoMute,
	outThreeMute,
	outDriverEnables,
	analogOutTwoEn,
	analogOutThreeEn,
	adcInputSelect,
	adcInputOneHot
);
	import codec_route_pkg::*;
	input wire logic clock;
	input wire logic nrst;
	input wire logic clockEn;
	input wire logic hsel;
	input wire logic [31:0] haddr;
	input wire logic [1:0] htrans;
	input wire logic hwrite;
	input wire logic [2:0] hsize;
	input wire logic [codec_route_pkg::DATA_W-1:0] hwdata;
	input wire logic hready;
	output logic [codec_route_pkg::DATA_W-1:0] hrdata;
	output logic hreadyout;
	output logic hresp;
	output logic [5:0] adcGain;
	output logic [5:0] dacGain;
	output logic [2:0] sidetoneGainSel;
	output logic sidetoneMute;
	output logic [4:0] sidetoneAttenDb;
	output logic [1:0] inputBufferGainSel;
	output logic [4:0] inputBufferGainDb;
	output logic outputEndedSel;
	output logic outTwoMute;
	output logic outThreeMute;
	output logic [1:0] outDriverEnables;
	output logic analogOutTwoEn;
	output logic analogOutThreeEn;
	output logic [1:0] adcInputSelect;
	output logic [3:0] adcInputOneHot;

	// Version field must fit its slot
	if ($bits(VERSION_ID) != VER_W) begin : gVersionCheck
		$error("VERSION_ID width must match the version field");
	end

	// Reset release synchroniser
	logic rstMeta_reg; // First stage, read only by the second
	logic rstSyncN_reg; // Released reset used everywhere else

	// Register storage
	logic [5:0] adcGain_reg; // ADC PGA gain byte
	logic [5:0] dacGain_reg; // DAC PGA gain byte
	logic [2:0] stg_reg; // Sidetone gain code
	logic [1:0] input_buffer_gain_sel_reg; // Input buffer gain code
	logic ended_reg; // Single-ended when set
	logic muteTwo_reg; // Output two mute
	logic muteThree_reg; // Output three mute
	logic [1:0] drv_reg; // Output driver enables
	logic [1:0] ain_reg; // ADC input source
	read_slot_type slot_reg; // Next group-five byte to read
	read_slot_type slot_next;
	logic [DATA_W-1:0] hrdata_reg; // Read data for the data phase
	logic [DATA_W-1:0] hrdata_next;

	// Decoded outputs, one cycle behind the fields
	logic stgMute_reg;
	logic [4:0] stgAtten_reg;
	logic [4:0] inbgDb_reg;
	logic [4:0] stgAtten_next;
	logic [4:0] inbgDb_next;
	logic [3:0] ainHot_reg;

	// Bus front end
	logic rdReq;
	logic [31:0] reqAddr;
	logic wrStrobe;
	logic [31:0] wrAddr;

	ahb_word_slave u_ahb_word_slave (
		.clock(clock),
		.rstN(rstSyncN_reg),
		.clockEn(clockEn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.rdReq(rdReq),
		.reqAddr(reqAddr),
		.wrStrobe(wrStrobe),
		.wrAddr(wrAddr)
	);

	// Address decode and write selection
	wire [BYTE_W-1:0] wrByte = hwdata[BYTE_W-1:0];
	wire [1:0] wrSub = wrByte[SUBSEL_HI:SUBSEL_LO];
	wire wrGroup = wrStrobe && (wrAddr == GROUP_FIVE_OFFSET);
	wire wrRouting = wrStrobe && (wrAddr == ROUTING_OFFSET);
	wire wrAdc = wrGroup && (wrSub == SUB_ADC_GAIN);
	wire wrDac = wrGroup && (wrSub == SUB_DAC_GAIN);
	wire wrSide = wrGroup && (wrSub == SUB_SIDETONE);
	// A version-select write carries no data; the field is read-only
	wire rdGroup = rdReq && (reqAddr == GROUP_FIVE_OFFSET);
	wire rdRouting = rdReq && (reqAddr == ROUTING_OFFSET);

	// Read bytes; the four group-five bytes are tagged with their select pattern
	wire [BYTE_W-1:0] adcByte = {SUB_ADC_GAIN, adcGain_reg};
	wire [BYTE_W-1:0] dacByte = {SUB_DAC_GAIN, dacGain_reg};
	wire [BYTE_W-1:0] sideByte = {SUB_SIDETONE, stg_reg, 1'b0, input_buffer_gain_sel_reg};
	wire [BYTE_W-1:0] verByte = {SUB_VERSION, 2'h0, VERSION_ID};
	wire [BYTE_W-1:0] routeByte = {ended_reg, muteTwo_reg, muteThree_reg, drv_reg, ain_reg, 1'b0};
	wire [BYTE_W-1:0] groupByte = (slot_reg == READ_DAC) ? dacByte :
		(slot_reg == READ_SIDE) ? sideByte :
		(slot_reg == READ_VER) ? verByte : adcByte;

	// Read sequencing: each group read moves on, a group write restarts at ADC
	always_comb begin
		slot_next = slot_reg;
		if (wrGroup) begin
			slot_next = READ_ADC;
		end else if (rdGroup) begin
			case (slot_reg)
				READ_ADC: slot_next = READ_DAC;
				READ_DAC: slot_next = READ_SIDE;
				READ_SIDE: slot_next = READ_VER;
				READ_VER: slot_next = READ_ADC;
				default: slot_next = READ_ADC;
			endcase
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb begin
		hrdata_next = hrdata_reg;
		if (rdGroup) begin
			hrdata_next = {{(DATA_W-BYTE_W){1'b0}}, groupByte};
		end else if (rdRouting) begin
			hrdata_next = {{(DATA_W-BYTE_W){1'b0}}, routeByte};
		end else if (rdReq) begin
			hrdata_next = '0;
		end
	end

	// Gain decode of the stored codes
	always_comb begin
		stgAtten_next = 5'h00;
		if (stg_reg != STG_MUTE_CODE) begin
			stgAtten_next = 5'(({2'h0, stg_reg} + 5'h01) * STG_STEP_DB);
		end
		case (input_buffer_gain_sel_reg)
			2'h0: inbgDb_next = INPUT_BUFFER_GAIN_SEL_DB_0;
			2'h1: inbgDb_next = INPUT_BUFFER_GAIN_SEL_DB_1;
			2'h2: inbgDb_next = INPUT_BUFFER_GAIN_SEL_DB_2;
			2'h3: inbgDb_next = INPUT_BUFFER_GAIN_SEL_DB_3;
			default: inbgDb_next = INPUT_BUFFER_GAIN_SEL_DB_0;
		endcase
	end

	// Reset release; the bus front end and registers stay in reset until both stages are set
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstMeta_reg <= 1'b0;
			rstSyncN_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSyncN_reg <= rstMeta_reg;
		end
	end

	// Group-five storage
	always_ff @(posedge clock or negedge rstSyncN_reg) begin
		if (!rstSyncN_reg) begin
			adcGain_reg <= PGA_RESET;
			dacGain_reg <= PGA_RESET;
			stg_reg <= STG_RESET;
			input_buffer_gain_sel_reg <= INPUT_BUFFER_GAIN_SEL_RESET;
		end else if (clockEn) begin
			if (wrAdc) begin
				adcGain_reg <= wrByte[PGA_HI:PGA_LO];
			end
			if (wrDac) begin
				dacGain_reg <= wrByte[PGA_HI:PGA_LO];
			end
			if (wrSide) begin
				stg_reg <= wrByte[STG_HI:STG_LO];
				input_buffer_gain_sel_reg <= wrByte[INPUT_BUFFER_GAIN_SEL_HI:INPUT_BUFFER_GAIN_SEL_LO];
			end
		end
	end

	// Routing storage; bit zero is reserved and not kept
	always_ff @(posedge clock or negedge rstSyncN_reg) begin
		if (!rstSyncN_reg) begin
			ended_reg <= ENDED_RESET;
			muteTwo_reg <= MUTE_RESET;
			muteThree_reg <= MUTE_RESET;
			drv_reg <= DRV_RESET;
			ain_reg <= AIN_RESET;
		end else if (clockEn && wrRouting) begin
			ended_reg <= wrByte[ENDED_BIT];
			muteTwo_reg <= wrByte[MUTE_TWO_BIT];
			muteThree_reg <= wrByte[MUTE_THREE_BIT];
			drv_reg <= wrByte[DRV_HI:DRV_LO];
			ain_reg <= wrByte[AIN_HI:AIN_LO];
		end
	end

	// Read pointer and read data
	always_ff @(posedge clock or negedge rstSyncN_reg) begin
		if (!rstSyncN_reg) begin
			slot_reg <= READ_ADC;
			hrdata_reg <= '0;
		end else if (clockEn) begin
			slot_reg <= slot_next;
			hrdata_reg <= hrdata_next;
		end
	end

	// Registered decode, so the analog side sees glitch-free levels
	always_ff @(posedge clock or negedge rstSyncN_reg) begin
		if (!rstSyncN_reg) begin
			stgMute_reg <= 1'b1;
			stgAtten_reg <= 5'h00;
			inbgDb_reg <= INPUT_BUFFER_GAIN_SEL_DB_0;
			ainHot_reg <= 4'h1;
		end else if (clockEn) begin
			stgMute_reg <= (stg_reg == STG_MUTE_CODE);
			stgAtten_reg <= stgAtten_next;
			inbgDb_reg <= inbgDb_next;
			ainHot_reg <= 4'h1 << ain_reg;
		end
	end

	// Outputs
	assign hrdata = hrdata_reg;
	assign adcGain = adcGain_reg;
	assign dacGain = dacGain_reg;
	assign sidetoneGainSel = stg_reg;
	assign sidetoneMute = stgMute_reg;
	assign sidetoneAttenDb = stgAtten_reg;
	assign inputBufferGainSel = input_buffer_gain_sel_reg;
	assign inputBufferGainDb = inbgDb_reg;
	assign outputEndedSel = ended_reg;
	assign outTwoMute = muteTwo_reg;
	assign outThreeMute = muteThree_reg;
	assign outDriverEnables = drv_reg;
	assign analogOutTwoEn = drv_reg[0];
	assign analogOutThreeEn = drv_reg[1];
	assign adcInputSelect = ain_reg;
	assign adcInputOneHot = ainHot_reg;
endmodule // codec_route_gain_regs

// *** dv/codec_route_gain_regs_checker.sv ***
// Checker for the routing and gain bank: bus writes against field outputs.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
module codec_route_gain_regs_checker (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clockEn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [codec_route_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	input wire logic [codec_route_pkg::DATA_W-1:0] hrdata,
	input wire logic [2:0] sidetoneGainSel,
	input wire logic sidetoneMute,
	input wire logic [4:0] sidetoneAttenDb,
	input wire logic [1:0] inputBufferGainSel,
	input wire logic [4:0] inputBufferGainDb,
	input wire logic outputEndedSel,
	input wire logic outTwoMute,
	input wire logic outThreeMute,
	input wire logic [1:0] outDriverEnables,
	input wire logic analogOutTwoEn,
	input wire logic analogOutThreeEn,
	input wire logic [1:0] adcInputSelect,
	input wire logic [3:0] adcInputOneHot
);
	import codec_route_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Accepted address phases; decoded from bus inputs only
	wire acc = hsel && hready && htrans[1] && hsize == HSIZE_WORD && clockEn;
	wire rdG = acc && !hwrite && haddr == GROUP_FIVE_OFFSET;
	wire wrG = acc && hwrite && haddr == GROUP_FIVE_OFFSET;
	wire wrR = acc && hwrite && haddr == ROUTING_OFFSET;
	wire [2:0] wStg = hwdata[5:3];
	wire [1:0] wIb = hwdata[1:0];
	wire [6:0] wRt = hwdata[7:1];
	// Expected slot of the next group read; a group write restarts it
	logic [1:0] slotReg;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			slotReg <= 2'h0;
		end else if (wrG) begin
			slotReg <= 2'h0;
		end else if (rdG) begin
			slotReg <= slotReg + 2'h1;
		end
	end
	function automatic logic [4:0] ibDb(input logic [1:0] c);
		return c == 2'h3 ? 5'h18 : c == 2'h2 ? 5'h0c : c == 2'h1 ? 5'h06 : 5'h00;
	endfunction
	stg_mute_a: assert property (sidetoneMute == ($past(sidetoneGainSel) == 3'h7))
		else $error("sidetone mute decode wrong");
	stg_atten_a: assert property (sidetoneGainSel != 3'h7 |=>
		sidetoneAttenDb == 5'(3 * ($past(sidetoneGainSel) + 1))) else $error("atten wrong");
	inbuf_db_a: assert property (inputBufferGainDb == ibDb($past(inputBufferGainSel)))
		else $error("input buffer gain wrong");
	drv_pins_a: assert property (analogOutTwoEn == outDriverEnables[0] &&
		analogOutThreeEn == outDriverEnables[1]) else $error("driver enables wrong");
	ain_hot_a: assert property (adcInputOneHot == 4'h1 << $past(adcInputSelect))
		else $error("input select decode wrong");
	route_write_a: assert property (wrR ##1 1'b1 |=> {outputEndedSel, outTwoMute,
		outThreeMute, outDriverEnables, adcInputSelect} == $past(wRt)) else $error("routing");
	side_write_a: assert property (wrG ##1 hwdata[7:6] == SUB_SIDETONE |=>
		sidetoneGainSel == $past(wStg) && inputBufferGainSel == $past(wIb)) else $error("side");
	ver_write_a: assert property (wrG ##1 hwdata[7:6] == SUB_VERSION |=>
		$stable(sidetoneGainSel) && $stable(inputBufferGainSel)) else $error("version write");
	read_order_a: assert property (rdG |=> hrdata[7:6] == $past(slotReg))
		else $error("group read order wrong");
	cover property (wrR);
	cover property (rdG ##2 rdG);
	cover property (wrG ##1 hwdata[7:6] == SUB_VERSION);
endmodule // codec_route_gain_regs_checker

bind codec_route_gain_regs codec_route_gain_regs_checker u_chk (.clock, .nrst, .clockEn,
	.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .sidetoneGainSel,
	.sidetoneMute, .sidetoneAttenDb, .inputBufferGainSel, .inputBufferGainDb,
	.outputEndedSel, .outTwoMute, .outThreeMute, .outDriverEnables, .analogOutTwoEn,
	.analogOutThreeEn, .adcInputSelect, .adcInputOneHot);

// *** dv/codec_route_gain_regs_test.sv ***
// Self-checking bench for the routing and gain bank over AHB-Lite.
// Assumes a single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module codec_route_gain_regs_test;
	import codec_route_pkg::*;
	localparam logic [3:0] VER = 4'h9; // Arbitrary version value
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic clockEn = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hready;
	wire logic [31:0] hrdata;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [5:0] adcGain;
	wire logic [5:0] dacGain;
	wire logic [2:0] sidetoneGainSel;
	wire logic sidetoneMute;
	wire logic [4:0] sidetoneAttenDb;
	wire logic [4:0] inputBufferGainDb;
	wire logic outputEndedSel;
	wire logic outTwoMute;
	wire logic outThreeMute;
	wire logic [1:0] outDriverEnables;
	wire logic analogOutTwoEn;
	wire logic analogOutThreeEn;
	wire logic [3:0] adcInputOneHot;
	logic [31:0] ibTab [4] = '{32'h0, 32'h6, 32'hc, 32'h18};
	int err_total = 0;
	int n_compared = 0;
	logic [2:0] szSel = HSIZE_WORD; // Transfer size used by the next transfer
	assign hready = hreadyout; // One slave on the bus
	codec_route_gain_regs #(.VERSION_ID(VER)) u_codec_route_gain_regs (.clock, .nrst,
		.clockEn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .adcGain, .dacGain, .sidetoneGainSel, .sidetoneMute,
		.sidetoneAttenDb, .inputBufferGainSel(), .inputBufferGainDb, .outputEndedSel,
		.outTwoMute, .outThreeMute, .outDriverEnables, .analogOutTwoEn, .analogOutThreeEn,
		.adcInputSelect(), .adcInputOneHot);
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic test_done();
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for hready sampled high at a rising edge
	task automatic waitRdy();
		int n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_total++;
			$display("[FAIL] hready expected 1 seen %b", hready);
			test_done();
		end
	endtask
	// One single transfer of size szSel: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= szSel;
		htrans <= HTRANS_NONSEQ;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [31:0] a, exp, input string nm);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(nm, exp, r);
	endtask
	initial begin
		logic [7:0] d;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		chk("ended", 0, outputEndedSel);
		chk("out_two_mute", 0, outTwoMute);
		chk("out_three_mute", 0, outThreeMute);
		chk("drv", 0, outDriverEnables);
		chk("hot", 1, adcInputOneHot);
		chk("stmute", 1, sidetoneMute);
		chk("ibdb", 0, inputBufferGainDb);
		chk("adcg", 32'(PGA_RESET), adcGain);
		chk("dacg", 32'(PGA_RESET), dacGain);
		rd(ROUTING_OFFSET, 32'h0, "route");
		// Group reads walk the four bytes, then wrap
		rd(GROUP_FIVE_OFFSET, 32'h2a, "adc");
		rd(GROUP_FIVE_OFFSET, 32'h6a, "dac");
		rd(GROUP_FIVE_OFFSET, 32'hb8, "side");
		rd(GROUP_FIVE_OFFSET, {28'hc, VER}, "ver");
		rd(GROUP_FIVE_OFFSET, 32'h2a, "wrap");
		// Every sidetone code, every buffer code
		for (int c = 0; c < 8; c++) begin
			d = {2'h2, 3'(c), 1'b0, 2'(c)};
			wr(GROUP_FIVE_OFFSET, 32'(d));
			repeat (2) @(posedge clock);
			chk("stmute", 32'(c == 7), sidetoneMute);
			chk("stdb", c == 7 ? 0 : 3 * (c + 1), sidetoneAttenDb);
			chk("ibdb", ibTab[c % 4], inputBufferGainDb);
		end
		// Version write changes nothing and restarts the read walk
		wr(GROUP_FIVE_OFFSET, 32'hff);
		rd(GROUP_FIVE_OFFSET, 32'h2a, "adc");
		rd(GROUP_FIVE_OFFSET, 32'h6a, "dac");
		rd(GROUP_FIVE_OFFSET, 32'hbb, "side");
		// ADC and DAC gain writes through the group select bits
		wr(GROUP_FIVE_OFFSET, 32'h15);
		wr(GROUP_FIVE_OFFSET, 32'h73);
		rd(GROUP_FIVE_OFFSET, 32'h15, "adc");
		rd(GROUP_FIVE_OFFSET, 32'h73, "dac");
		chk("adcg", 32'h15, adcGain);
		chk("dacg", 32'h33, dacGain);
		chk("hresp", 0, hresp);
		for (int k = 0; k < 4; k++) begin
			d = {k[0], k[1], ~k[1], 2'(k), 2'(3 - k), 1'b1};
			wr(ROUTING_OFFSET, 32'(d));
			rd(ROUTING_OFFSET, 32'(d & 8'hfe), "route");
			chk("ended", k % 2, outputEndedSel);
			chk("out_two_mute", k / 2, outTwoMute);
			chk("out_three_mute", 1 - k / 2, outThreeMute);
			chk("out2", k % 2, analogOutTwoEn);
			chk("out3", k / 2, analogOutThreeEn);
			chk("hot", 1 << (3 - k), adcInputOneHot);
		end
		// Byte-size write is refused; routing must keep its value
		szSel = 3'h0;
		wr(ROUTING_OFFSET, 32'h0);
		szSel = HSIZE_WORD;
		// Unmapped place: writes dropped, reads zero
		wr(32'h8, 32'hff);
		rd(32'h8, 32'h0, "unmapped");
		rd(ROUTING_OFFSET, 32'hd8, "route");
		clockEn <= 1'b0;
		repeat (2) @(posedge clock);
		chk("stall", 0, hreadyout);
		clockEn <= 1'b1;
		// Reset in mid-run restores defaults
		nrst <= 1'b0;
		@(posedge clock);
		chk("ended", 0, outputEndedSel);
		chk("drv", 0, outDriverEnables);
		chk("stsel", 7, sidetoneGainSel);
		chk("adcg", 32'(PGA_RESET), adcGain);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		rd(GROUP_FIVE_OFFSET, 32'h2a, "adc");
		test_done();
	end
endmodule // codec_route_gain_regs_test
